/* File: tveio_consts.svh */
// Offsets, defaults, write masks, codes and fixed levels of the encoder control registers
`ifndef TVEIO_CONSTS_SVH
`define TVEIO_CONSTS_SVH

`define TVEIO_DEV_ADDR        7'h3B
`define TVEIO_OFF_INPUT_CLOCK 8'h1D
`define TVEIO_OFF_GPIO        8'h1E
`define TVEIO_OFF_IDF         8'h1F
`define TVEIO_OFF_CD          8'h20
`define TVEIO_OFF_DC          8'h21
`define TVEIO_OFF_BCO         8'h22
`define TVEIO_OFF_TEST_AND_SOFT_RESET        8'h48
`define TVEIO_OFF_PM          8'h49

`define TVEIO_RST_INPUT_CLOCK 8'h88
`define TVEIO_RST_GPIO        8'hC0
`define TVEIO_RST_IDF         8'h00
`define TVEIO_RST_CD          8'h00
`define TVEIO_RST_DC          8'h00
`define TVEIO_RST_BCO         8'h00
`define TVEIO_RST_TEST_AND_SOFT_RESET        8'h18
`define TVEIO_RST_PM          8'h01

`define TVEIO_CD_RW_MASK      8'hC1
`define TVEIO_DC_RW_MASK      8'hDF
`define TVEIO_TEST_AND_SOFT_RESET_RW_MASK    8'h1F
`define TVEIO_READ_NONE       8'h00

`define TVEIO_FMT_YCRCB       3'h4
`define TVEIO_K3_BASE         4'h5
`define TVEIO_K3_CODE_SIX     3'h6
`define TVEIO_K3_HALF_SIX     4'hC
`define TVEIO_K3_HALF_SEVEN   4'hE
`define TVEIO_DAC_SENSE_LEVEL 10'h3FF
`define TVEIO_DAC_IDLE        10'h000
`define TVEIO_BITS_PER_BYTE   4'h8
`define TVEIO_LAST_BIT        4'h7

`endif

/* File: tveio_pkg.sv */
// Types shared by the encoder control register block
package tveio_pkg;
	typedef enum logic [3:0] {
		TVEIO_IDLE  = 4'b0000,
		TVEIO_ADDR  = 4'b0001,
		TVEIO_ACK_A = 4'b0010,
		TVEIO_PTR   = 4'b0011,
		TVEIO_ACK_P = 4'b0100,
		TVEIO_WDATA = 4'b0101,
		TVEIO_ACK_W = 4'b0110,
		TVEIO_RDATA = 4'b0111,
		TVEIO_MACK  = 4'b1000,
		TVEIO_RLOAD = 4'b1001
	} tveio_serial_state_t;

	typedef enum logic [1:0] {
		TVEIO_PAT_LIVE = 2'b00,
		TVEIO_PAT_BARS = 2'b01,
		TVEIO_PAT_RAMP = 2'b10
	} tveio_pattern_t;
endpackage

/* File: tveio_reg_if.sv */
// Register access carrier between serial slave and register bank
`timescale 1ns/100ps
`default_nettype none
interface tveio_reg_if;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slave (output wr, output addr, output wdata, input rdata);
	modport bank  (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: tveio_sync.sv */
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module tveio_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

/* File: tveio_serial_slave.sv */
// Two-wire serial slave with register pointer and auto-increment
`timescale 1ns/100ps
`default_nettype none
`include "tveio_consts.svh"
module tveio_serial_slave
	import tveio_pkg::*;
(
	input  wire logic   sys_clk,
	input  wire logic   resetn,
	input  wire logic   scl_s,
	input  wire logic   sda_s,
	output var  logic   sda_oe,
	tveio_reg_if.slave  rif
);
	tveio_serial_state_t state, next_state;
	logic [3:0] bitcnt, next_bitcnt;
	logic [7:0] shreg, next_shreg;
	logic [7:0] ptr, next_ptr;
	logic       rw, next_rw;
	logic       drive, next_drive;
	logic       scl_q, sda_q;
	logic       start, stop, rise, fall;

	assign start = scl_s & scl_q & sda_q & ~sda_s;
	assign stop  = scl_s & scl_q & ~sda_q & sda_s;
	assign rise  = scl_s & ~scl_q;
	assign fall  = ~scl_s & scl_q;
	assign sda_oe    = drive;
	assign rif.addr  = ptr;
	assign rif.wdata = shreg;

	always_comb begin
		next_state  = state;
		next_bitcnt = bitcnt;
		next_shreg  = shreg;
		next_ptr    = ptr;
		next_rw     = rw;
		next_drive  = drive;
		rif.wr      = 1'b0;
		if (start) begin
			next_state  = TVEIO_ADDR;
			next_bitcnt = 4'h0;
			next_drive  = 1'b0;
		end else if (stop) begin
			next_state = TVEIO_IDLE;
			next_drive = 1'b0;
		end else begin
			case (state)
				TVEIO_ADDR, TVEIO_PTR, TVEIO_WDATA: begin
					if (rise) begin
						next_shreg  = {shreg[6:0], sda_s};
						next_bitcnt = bitcnt + 4'h1;
					end else if (fall && bitcnt == `TVEIO_BITS_PER_BYTE) begin
						next_bitcnt = 4'h0;
						next_drive  = 1'b1;
						if (state == TVEIO_ADDR) begin
							next_rw    = shreg[0];
							next_state = TVEIO_ACK_A;
							if (shreg[7:1] != `TVEIO_DEV_ADDR) begin
								next_state = TVEIO_IDLE;
								next_drive = 1'b0;
							end
						end else if (state == TVEIO_PTR) begin
							next_ptr   = shreg;
							next_state = TVEIO_ACK_P;
						end else begin
							rif.wr     = 1'b1;
							next_state = TVEIO_ACK_W;
						end
					end
				end
				TVEIO_ACK_A: begin
					if (fall) begin
						if (rw) begin
							next_shreg = rif.rdata;
							next_drive = ~rif.rdata[7];
							next_state = TVEIO_RDATA;
						end else begin
							next_drive = 1'b0;
							next_state = TVEIO_PTR;
						end
					end
				end
				TVEIO_ACK_P, TVEIO_ACK_W: begin
					if (fall) begin
						next_drive = 1'b0;
						next_state = TVEIO_WDATA;
						if (state == TVEIO_ACK_W)
							next_ptr = ptr + 8'h01;
					end
				end
				TVEIO_RDATA: begin
					if (fall) begin
						if (bitcnt == `TVEIO_LAST_BIT) begin
							next_drive  = 1'b0;
							next_bitcnt = 4'h0;
							next_ptr    = ptr + 8'h01;
							next_state  = TVEIO_MACK;
						end else begin
							next_bitcnt = bitcnt + 4'h1;
							next_shreg  = {shreg[6:0], 1'b0};
							next_drive  = ~shreg[6];
						end
					end
				end
				TVEIO_MACK: begin
					if (rise)
						next_state = sda_s ? TVEIO_IDLE : TVEIO_RLOAD;
				end
				TVEIO_RLOAD: begin
					if (fall) begin
						next_shreg = rif.rdata;
						next_drive = ~rif.rdata[7];
						next_state = TVEIO_RDATA;
					end
				end
				default: next_state = TVEIO_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state  <= TVEIO_IDLE;
			bitcnt <= 4'h0;
			shreg  <= 8'h00;
			ptr    <= 8'h00;
			rw     <= 1'b0;
			drive  <= 1'b0;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
		end else begin
			state  <= next_state;
			bitcnt <= next_bitcnt;
			shreg  <= next_shreg;
			ptr    <= next_ptr;
			rw     <= next_rw;
			drive  <= next_drive;
			scl_q  <= scl_s;
			sda_q  <= sda_s;
		end
	end
endmodule
`default_nettype wire

/* File: tveio_regs.sv */
// TV encoder I/O control and status registers behind the two-wire serial port
`timescale 1ns/100ps
`default_nettype none
`include "tveio_consts.svh"
module tveio_regs
	import tveio_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output var  logic        sda_out,
	output var  logic        sda_oe,
	input  wire logic [1:0]  gpio_in,
	output var  logic [1:0]  gpio_out,
	output var  logic [1:0]  gpio_oe,
	input  wire logic        hsync_in,
	input  wire logic        vsync_in,
	output var  logic        hsync_out,
	output var  logic        vsync_out,
	output var  logic        sync_oe,
	input  wire logic [3:0]  dac_compare_in,
	input  wire logic        pixclk_src,
	output var  logic        pixclk_out,
	output var  logic        pixclk_oe,
	input  wire logic        tv_hsync,
	input  wire logic        tv_vsync,
	input  wire logic        tv_csync,
	input  wire logic        emb_hsync,
	input  wire logic        emb_vsync,
	output var  logic        core_hsync,
	output var  logic        core_vsync,
	input  wire logic        crystal_clk,
	input  wire logic        vco_div_clk,
	input  wire logic        field_id,
	output var  logic        csync_out,
	output var  logic        csync_oe,
	output var  logic        aux_clock_out,
	output var  logic        aux_clock_oe,
	output var  logic [3:0]  vco_output_divider,
	input  wire logic [29:0] bypass_pixels,
	input  wire logic [39:0] enc_dac,
	output var  logic [39:0] dac_out,
	output var  logic [3:0]  input_clock_delay,
	output var  logic [2:0]  input_format_field,
	output var  logic        input_buffer_select,
	output var  logic [2:0]  crystal_osc_adjust,
	output var  logic [1:0]  dac_gain_bit,
	output var  logic        dac_bypass,
	output var  logic [1:0]  test_pattern,
	output var  logic        datapath_reset_n,
	output var  logic        encoder_run,
	output var  logic [3:0]  dac_run,
	output var  logic        pll_run
);
	tveio_reg_if rif ();

	logic [7:0] input_clock, next_input_clock;
	logic [7:0] general_pin_control, next_general_pin_control;
	logic [7:0] input_format_control, next_input_format_control;
	logic [7:0] connection_detect, next_connection_detect;
	logic [7:0] dac_control, next_dac_control;
	logic [7:0] buffered_clock_output, next_buffered_clock_output;
	logic [7:0] test_and_soft_reset, next_test_and_soft_reset;
	logic [7:0] power_management, next_power_management;
	logic [3:0] dac_detect_flag, next_dac_detect_flag;
	logic       sense_q, next_sense_q;
	logic [39:0] next_dac_out;
	logic       scl_s, sda_s, hs_s, vs_s;
	logic [1:0] gpio_s;
	logic [3:0] cmp_s;
	logic [1:0] pin_level, pin_direction;
	logic [7:0] gpio_read;
	logic       sense, full_power_down, register_soft_reset;
	logic       hs_norm, vs_norm, use_embedded, aux_sel_sig;
	logic [2:0] aux_clock_select, vco_divider_select;
	logic [1:0] sync_output_select;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers and serial slave
	tveio_sync #(.WIDTH(10)) u_sync (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.async_in ({scl_in, sda_in, hsync_in, vsync_in, gpio_in, dac_compare_in}),
		.sync_out ({scl_s, sda_s, hs_s, vs_s, gpio_s, cmp_s})
	);

	tveio_serial_slave u_slave (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.scl_s   (scl_s),
		.sda_s   (sda_s),
		.sda_oe  (sda_oe),
		.rif     (rif)
	);

	assign sda_out = 1'b0;

	////////////////////////////////////////////////////////////////
	// Field views
	assign pin_direction       = general_pin_control[7:6];
	assign pin_level           = general_pin_control[5:4];
	assign sense               = connection_detect[0];
	assign full_power_down     = power_management[0];
	assign register_soft_reset = test_and_soft_reset[4];
	assign sync_output_select  = dac_control[4:3];
	assign aux_clock_select    = buffered_clock_output[2:0];
	assign vco_divider_select  = buffered_clock_output[7:5];

	assign gpio_read = {general_pin_control[7:6],
		pin_direction[1] ? gpio_s[1] : pin_level[1],
		pin_direction[0] ? gpio_s[0] : pin_level[0],
		general_pin_control[3:0]};

	////////////////////////////////////////////////////////////////
	// Register read mux
	always_comb begin
		case (rif.addr)
			`TVEIO_OFF_INPUT_CLOCK: rif.rdata = input_clock;
			`TVEIO_OFF_GPIO:        rif.rdata = gpio_read;
			`TVEIO_OFF_IDF:         rif.rdata = input_format_control;
			`TVEIO_OFF_CD:          rif.rdata = {connection_detect[7:6], 1'b0,
				dac_detect_flag, connection_detect[0]};
			`TVEIO_OFF_DC:          rif.rdata = dac_control & `TVEIO_DC_RW_MASK;
			`TVEIO_OFF_BCO:         rif.rdata = buffered_clock_output;
			`TVEIO_OFF_TEST_AND_SOFT_RESET:        rif.rdata = test_and_soft_reset & `TVEIO_TEST_AND_SOFT_RESET_RW_MASK;
			`TVEIO_OFF_PM:          rif.rdata = power_management;
			default:                rif.rdata = `TVEIO_READ_NONE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Register write and soft reset
	always_comb begin
		next_input_clock           = input_clock;
		next_general_pin_control   = general_pin_control;
		next_input_format_control  = input_format_control;
		next_connection_detect     = connection_detect;
		next_dac_control           = dac_control;
		next_buffered_clock_output = buffered_clock_output;
		next_test_and_soft_reset   = test_and_soft_reset;
		next_power_management      = power_management;
		next_dac_detect_flag       = dac_detect_flag;
		next_sense_q               = sense;
		if (sense_q && !sense)
			next_dac_detect_flag = cmp_s;
		if (!register_soft_reset) begin
			next_input_clock           = `TVEIO_RST_INPUT_CLOCK;
			next_general_pin_control   = `TVEIO_RST_GPIO;
			next_input_format_control  = `TVEIO_RST_IDF;
			next_connection_detect     = `TVEIO_RST_CD;
			next_dac_control           = `TVEIO_RST_DC;
			next_buffered_clock_output = `TVEIO_RST_BCO;
			next_test_and_soft_reset   = `TVEIO_RST_TEST_AND_SOFT_RESET;
			next_power_management      = `TVEIO_RST_PM;
			next_dac_detect_flag       = 4'h0;
			next_sense_q               = 1'b0;
		end else if (rif.wr) begin
			case (rif.addr)
				`TVEIO_OFF_INPUT_CLOCK: next_input_clock = rif.wdata;
				`TVEIO_OFF_GPIO:        next_general_pin_control = rif.wdata;
				`TVEIO_OFF_IDF:         next_input_format_control = rif.wdata;
				`TVEIO_OFF_CD:          next_connection_detect = rif.wdata & `TVEIO_CD_RW_MASK;
				`TVEIO_OFF_DC:          next_dac_control = rif.wdata & `TVEIO_DC_RW_MASK;
				`TVEIO_OFF_BCO:         next_buffered_clock_output = rif.wdata;
				`TVEIO_OFF_TEST_AND_SOFT_RESET:        next_test_and_soft_reset = rif.wdata & `TVEIO_TEST_AND_SOFT_RESET_RW_MASK;
				`TVEIO_OFF_PM:          next_power_management = rif.wdata;
				default:                next_input_clock = input_clock;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			input_clock           <= `TVEIO_RST_INPUT_CLOCK;
			general_pin_control   <= `TVEIO_RST_GPIO;
			input_format_control  <= `TVEIO_RST_IDF;
			connection_detect     <= `TVEIO_RST_CD;
			dac_control           <= `TVEIO_RST_DC;
			buffered_clock_output <= `TVEIO_RST_BCO;
			test_and_soft_reset   <= `TVEIO_RST_TEST_AND_SOFT_RESET;
			power_management      <= `TVEIO_RST_PM;
			dac_detect_flag       <= 4'h0;
			sense_q               <= 1'b0;
		end else begin
			input_clock           <= next_input_clock;
			general_pin_control   <= next_general_pin_control;
			input_format_control  <= next_input_format_control;
			connection_detect     <= next_connection_detect;
			dac_control           <= next_dac_control;
			buffered_clock_output <= next_buffered_clock_output;
			test_and_soft_reset   <= next_test_and_soft_reset;
			power_management      <= next_power_management;
			dac_detect_flag       <= next_dac_detect_flag;
			sense_q               <= next_sense_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Control field outputs and power gating
	assign input_clock_delay   = input_clock[3:0];
	assign input_format_field  = input_format_control[2:0];
	assign input_buffer_select = input_format_control[7];
	assign crystal_osc_adjust  = {connection_detect[6], dac_control[7:6]};
	assign dac_gain_bit        = dac_control[2:1];
	assign dac_bypass          = dac_control[0];
	assign datapath_reset_n    = resetn & test_and_soft_reset[3];
	assign encoder_run         = power_management[5] & ~full_power_down;
	assign dac_run             = ~power_management[4:1] & {4{~full_power_down}};
	assign pll_run             = ~full_power_down;

	always_comb begin
		case (test_and_soft_reset[1:0])
			2'b00:   test_pattern = TVEIO_PAT_LIVE;
			2'b01:   test_pattern = TVEIO_PAT_BARS;
			default: test_pattern = TVEIO_PAT_RAMP;
		endcase
	end

	assign gpio_out = pin_level;
	assign gpio_oe  = ~pin_direction;

	assign pixclk_out = pixclk_src ^ general_pin_control[0];
	assign pixclk_oe  = general_pin_control[1] & ~full_power_down;

	////////////////////////////////////////////////////////////////
	// Sync handling
	assign hs_norm = input_format_control[3] ? hs_s : ~hs_s;
	assign vs_norm = input_format_control[4] ? vs_s : ~vs_s;
	assign use_embedded = input_format_control[6]
		& (input_format_field == `TVEIO_FMT_YCRCB);
	assign core_hsync = use_embedded ? emb_hsync : hs_norm;
	assign core_vsync = use_embedded ? emb_vsync : vs_norm;
	assign hsync_out = input_format_control[3] ? tv_hsync : ~tv_hsync;
	assign vsync_out = input_format_control[4] ? tv_vsync : ~tv_vsync;
	assign sync_oe = input_format_control[5] & encoder_run & ~dac_bypass;

	always_comb begin
		case (sync_output_select)
			2'b01:   csync_out = core_hsync;
			2'b10:   csync_out = tv_csync;
			2'b11:   csync_out = tv_hsync;
			default: csync_out = 1'b0;
		endcase
	end
	assign csync_oe = (sync_output_select != 2'b00) & ~full_power_down;

	////////////////////////////////////////////////////////////////
	// Buffered clock output and divider
	always_comb begin
		case (aux_clock_select)
			3'b000:  aux_sel_sig = crystal_clk;
			3'b010:  aux_sel_sig = vco_div_clk;
			3'b011:  aux_sel_sig = field_id;
			3'b110:  aux_sel_sig = core_vsync;
			3'b111:  aux_sel_sig = tv_vsync;
			default: aux_sel_sig = 1'b0;
		endcase
	end
	assign aux_clock_out = buffered_clock_output[3] ? aux_sel_sig : ~aux_sel_sig;
	assign aux_clock_oe  = buffered_clock_output[4] & ~full_power_down;

	always_comb begin
		if (vco_divider_select < `TVEIO_K3_CODE_SIX)
			vco_output_divider = {1'b0, vco_divider_select} + `TVEIO_K3_BASE;
		else if (vco_divider_select == `TVEIO_K3_CODE_SIX)
			vco_output_divider = `TVEIO_K3_HALF_SIX;
		else
			vco_output_divider = `TVEIO_K3_HALF_SEVEN;
	end

	////////////////////////////////////////////////////////////////
	// DAC data path select
	always_comb begin
		if (sense)
			next_dac_out = {4{`TVEIO_DAC_SENSE_LEVEL}};
		else if (dac_bypass)
			next_dac_out = {`TVEIO_DAC_IDLE, bypass_pixels};
		else
			next_dac_out = enc_dac;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			dac_out <= {4{`TVEIO_DAC_IDLE}};
		else
			dac_out <= next_dac_out;
	end
endmodule
`default_nettype wire

/* File: tveio_regs_chk.sv */
// Port-level assertions for the encoder control register block
`timescale 1ns/100ps
`default_nettype none
module tveio_regs_chk (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        scl_in,
	input wire logic        pixclk_oe,
	input wire logic        encoder_run,
	input wire logic [3:0]  dac_run,
	input wire logic        pll_run,
	input wire logic        dac_bypass,
	input wire logic [39:0] dac_out,
	input wire logic [29:0] bypass_pixels,
	input wire logic        sync_oe,
	input wire logic        aux_clock_oe,
	input wire logic [3:0]  vco_output_divider,
	input wire logic [1:0]  test_pattern,
	input wire logic [3:0]  input_clock_delay
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	pix_gate_a: assert property (pixclk_oe |-> pll_run)
		else $error("pixel clock driven while powered down");
	enc_gate_a: assert property (encoder_run |-> pll_run)
		else $error("encoder runs in full power down");
	dac_gate_a: assert property (dac_run != 4'h0 |-> pll_run)
		else $error("dac runs in full power down");
	aux_gate_a: assert property (aux_clock_oe |-> pll_run)
		else $error("aux clock driven while powered down");
	sync_drive_a: assert property (sync_oe |-> encoder_run && !dac_bypass)
		else $error("sync pins driven outside encoder mode");
	bypass_route_a: assert property (
		$past(dac_bypass) |-> dac_out == {10'h000, $past(bypass_pixels)})
		else $error("bypass data not routed to dacs");
	k3_range_a: assert property (
		vco_output_divider inside {[4'h5:4'hA], 4'hC, 4'hE})
		else $error("divider code outside table");
	ramp_code_a: assert property (test_pattern != 2'b11)
		else $error("pattern code not folded");
	delay_update_a: assert property ($changed(input_clock_delay) |-> !scl_in)
		else $error("delay field changed outside byte end");
endmodule
bind tveio_regs tveio_regs_chk chk_u (.*);
`default_nettype wire

/* File: tveio_host.sv */
// Two-wire bus host model driving the register port
`timescale 1ns/100ps
`default_nettype none
`include "tveio_consts.svh"
module tveio_host (
	input  wire logic sys_clk,
	input  wire logic sda_line,
	output var  logic scl,
	output var  logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	////////////////////////////////////////
	task automatic hp();
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_low <= !b;
		hp();
		scl <= 1'b1;
		hp();
		r = sda_line;
		scl <= 1'b0;
		hp();
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(1'b1, a);
	endtask
	task automatic start();
		sda_low <= 1'b1;
		hp();
		scl <= 1'b0;
		hp();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		hp();
		scl <= 1'b1;
		hp();
		sda_low <= 1'b0;
		hp();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({`TVEIO_DEV_ADDR, 1'b0}, q);
		xfer(a, q);
		xfer(d, q);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({`TVEIO_DEV_ADDR, 1'b0}, q);
		xfer(a, q);
		stop();
		start();
		xfer({`TVEIO_DEV_ADDR, 1'b1}, q);
		xfer(8'hFF, d);
		stop();
	endtask
endmodule
`default_nettype wire

/* File: tveio_regs_tb.sv */
// Self-checking bench for the encoder control register block
`timescale 1ns/100ps
`default_nettype none
module tveio_regs_tb;
	logic sys_clk, resetn, scl_in, sda_low, hsync_in, vsync_in, pixclk_src;
	logic tv_hsync, tv_vsync, tv_csync, emb_hsync, emb_vsync, crystal_clk, vco_div_clk, field_id;
	logic sda_out, sda_oe, hsync_out, vsync_out, sync_oe, pixclk_out, pixclk_oe, core_hsync;
	logic core_vsync, csync_out, csync_oe, aux_clock_out, aux_clock_oe, input_buffer_select;
	logic dac_bypass, datapath_reset_n, encoder_run, pll_run;
	logic [1:0]  gpio_in, gpio_out, gpio_oe, dac_gain_bit, test_pattern;
	logic [2:0]  input_format_field, crystal_osc_adjust;
	logic [3:0]  dac_compare_in, vco_output_divider, input_clock_delay, dac_run;
	logic [29:0] bypass_pixels;
	logic [39:0] enc_dac, dac_out;
	wire         sda_in;
	int          mismatches = 0;
	int          n_compared = 0;
	int          cycles = 0;
	assign sda_in = !(sda_oe | sda_low);
	tveio_regs dut_u (.*);
	tveio_host host_u (.sys_clk(sys_clk), .sda_line(sda_in), .scl(scl_in), .sda_low(sda_low));
	////////////////////////////////////////
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		host_u.rd(a, q);
		chk(40'(q), 40'(e));
	endtask
	task automatic final_report();
		$display("compared=%0d mismatches=%0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		logic [71:0] a;
		logic [71:0] e;
		a = 72'h1D_1E_1F_20_21_22_48_49_30;
		e = 72'h88_C0_00_00_00_00_18_01_00;
		for (int i = 0; i < 9; i++) begin
			rchk(a[8*i +: 8], e[8*i +: 8]);
		end
	endtask
	task automatic t_pins();
		pixclk_src <= 1'b1;
		gpio_in <= 2'b10;
		host_u.wr(8'h49, 8'h20);
		host_u.wr(8'h1E, 8'h13);
		chk(40'({gpio_oe, gpio_out, pixclk_oe, pixclk_out}), 40'h36);
		host_u.wr(8'h1E, 8'hC0);
		chk(40'({gpio_oe, pixclk_oe}), 40'h0);
		rchk(8'h1E, 8'hE0);
	endtask
	task automatic t_fmt();
		logic [6:0] g;
		{tv_hsync, hsync_in, emb_hsync} <= 3'b101;
		{tv_vsync, vsync_in, emb_vsync} <= 3'b110;
		host_u.wr(8'h1F, 8'hFC);
		g = {input_format_field, input_buffer_select, sync_oe, hsync_out, core_hsync};
		chk(40'(g), 40'h4F);
		chk(40'({vsync_out, core_vsync}), 40'h2);
		{emb_hsync, vsync_in} <= 2'b00;
		host_u.wr(8'h1F, 8'h43);
		g = {input_format_field, input_buffer_select, sync_oe, hsync_out, core_hsync};
		chk(40'(g), 40'h31);
		chk(40'({vsync_out, core_vsync}), 40'h1);
	endtask
	task automatic t_sense();
		host_u.wr(8'h49, 8'h20);
		host_u.wr(8'h20, 8'h41);
		chk(dac_out, {4{10'h3FF}});
		dac_compare_in <= 4'hA;
		host_u.wr(8'h20, 8'h40);
		rchk(8'h20, 8'h54);
		host_u.wr(8'h21, 8'hC0);
		chk(40'(crystal_osc_adjust), 40'h7);
	endtask
	task automatic t_dac();
		logic [3:0] ex;
		ex = 4'b0110;
		bypass_pixels <= 30'h2345_6789;
		enc_dac <= 40'h12_3456_789A;
		{tv_hsync, tv_csync} <= 2'b01;
		host_u.wr(8'h21, 8'h03);
		chk(dac_out, {10'h000, 30'h2345_6789});
		chk(40'({dac_gain_bit, dac_bypass}), 40'h3);
		for (int s = 0; s < 4; s++) begin
			host_u.wr(8'h21, 8'(s * 8));
			chk(40'(csync_out & csync_oe), 40'(ex[s]));
		end
		chk(dac_out, 40'h12_3456_789A);
	endtask
	task automatic t_aux();
		logic [2:0] c [4];
		logic [3:0] k;
		c = '{3'h0, 3'h2, 3'h3, 3'h7};
		{crystal_clk, vco_div_clk, field_id, tv_vsync} <= 4'b1010;
		for (int i = 0; i < 8; i++) begin
			host_u.wr(8'h22, {3'(i), 1'b1, (i < 4), c[i % 4]});
			k = (i < 6) ? 4'(i + 5) : ((i == 6) ? 4'hC : 4'hE);
			chk(40'({aux_clock_oe, aux_clock_out, vco_output_divider}),
				40'({1'b1, ~(i[0] ^ i[2]), k}));
		end
		host_u.wr(8'h22, 8'h1E);
		chk(40'({aux_clock_oe, aux_clock_out}), 40'h3);
		host_u.wr(8'h22, 8'h08);
		chk(40'(aux_clock_oe), 40'h0);
	endtask
	task automatic t_test_and_soft_reset();
		for (int p = 0; p < 4; p++) begin
			host_u.wr(8'h48, 8'h18 | 8'(p));
			chk(40'(test_pattern), (p > 1) ? 40'h2 : 40'(p));
		end
		host_u.wr(8'h48, 8'h10);
		chk(40'(datapath_reset_n), 40'h0);
		host_u.wr(8'h1D, 8'h05);
		chk(40'(input_clock_delay), 40'h5);
		host_u.wr(8'h48, 8'h08);
		rchk(8'h1D, 8'h88);
		chk(40'(datapath_reset_n), 40'h1);
	endtask
	task automatic t_power();
		logic [31:0] v;
		logic [7:0] m;
		v = 32'h21_20_3E_0A;
		for (int i = 0; i < 4; i++) begin
			m = v[8*i +: 8];
			host_u.wr(8'h49, m);
			chk(40'({encoder_run, dac_run, pll_run}),
				40'({m[5] & !m[0], ~m[4:1] & {4{!m[0]}}, !m[0]}));
		end
		rchk(8'h49, 8'h21);
	endtask
	////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		resetn = 1'b0;
		{hsync_in, vsync_in, pixclk_src, tv_hsync, tv_vsync, tv_csync} = '0;
		{emb_hsync, emb_vsync, crystal_clk, vco_div_clk, field_id} = '0;
		{gpio_in, dac_compare_in, bypass_pixels, enc_dac} = '0;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_pins();
		t_fmt();
		t_sense();
		t_dac();
		t_aux();
		t_test_and_soft_reset();
		t_power();
		final_report();
	end
endmodule
`default_nettype wire
